// ### logic/dscd_top.sv
`default_nettype none
module dscd_top (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sclk_in,
    input  wire logic sync_n_in,
    input  wire logic sdin,
    output var  logic serial_readback_out,
    output var  logic serial_readback_oe_n,
    input  wire logic io_pin_zero_in,
    output var  logic io_pin_zero_out,
    output var  logic io_pin_zero_oe_n,
    input  wire logic io_pin_one_in,
    output var  logic io_pin_one_out,
    output var  logic io_pin_one_oe_n,
    output var  logic local_gnd_adj_en,
    output var  logic dac_clear_pulse,
    output var  logic dac_load_pulse
);
    import dscd_pkg::*;

    logic [2:0]       sclk_q, sync_q;
    logic [1:0]       din_q, io0_q, io1_q;
    logic             sclk_fall, sclk_rise, sync_fall, sync_rise, frame_act;
    logic [4:0]       cnt_reg;
    logic [23:0]      shift_reg, frame_reg, rb_word;
    logic             exec_reg, rb_out_reg, rb_load, mem_we, all_reg;
    logic             cmd_rd;
    logic [2:0]       cmd_sel, cmd_ch;
    logic [15:0]      cmd_data, rdata, ctrl_view;
    logic [5:0]       ctrl_reg, ctrl_next;
    logic [1:0]       chan_reg;
    logic             wipe_reg, load_reg;
    logic             exec_func, exec_reg_ok;
    dscd_state_t      state_reg;

    // Channel register type index, valid for select codes 010..101
    function automatic logic [1:0] mem_type(input logic [2:0] sel);
        logic [2:0] t;
        t = sel - SEL_DATA;
        return t[1:0];
    endfunction

    function automatic logic is_chan_sel(input logic [2:0] sel);
        return (sel >= SEL_DATA) && (sel <= SEL_OFFSET);
    endfunction

    function automatic logic [15:0] field_mask(input logic [2:0] sel);
        case (sel)
            SEL_COARSE: return MASK_COARSE;
            SEL_FINE:   return MASK_FINE;
            SEL_OFFSET: return MASK_OFFSET;
            default:    return MASK_DATA;
        endcase
    endfunction

    // Two-stage synchronisers for pins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q <= 3'h0;
            sync_q <= 3'h7;
            din_q  <= 2'h0;
            io0_q  <= 2'h3;
            io1_q  <= 2'h3;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], sclk_in};
            sync_q <= {sync_q[1:0], sync_n_in};
            din_q  <= {din_q[0], sdin};
            io0_q  <= {io0_q[0], io_pin_zero_in};
            io1_q  <= {io1_q[0], io_pin_one_in};
        end
    end

    // Edge detection on second and third stages
    assign sclk_fall = sclk_q[2] & ~sclk_q[1];
    assign sclk_rise = ~sclk_q[2] & sclk_q[1];
    assign sync_fall = sync_q[2] & ~sync_q[1];
    assign sync_rise = ~sync_q[2] & sync_q[1];
    assign frame_act = ~sync_q[1];

    // Falling edge counter, restarted by select fall
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= 5'h00;
        end
        else if (sync_fall)
        begin
            cnt_reg <= 5'h00;
        end
        else if (frame_act && sclk_fall && cnt_reg != CNT_MAX)
        begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // Input shift, MSB first; readback word replaces it between frames
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg <= 24'h000000;
        end
        else if (rb_load)
        begin
            shift_reg <= rb_word;
        end
        else if (frame_act && sclk_fall)
        begin
            shift_reg <= {shift_reg[22:0], din_q[1]};
        end
    end

    // Latch frame on select rise when enough edges were seen
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_reg <= 24'h000000;
            exec_reg  <= 1'b0;
        end
        else
        begin
            exec_reg <= sync_rise && (cnt_reg >= 5'(FRAME_BITS));
            if (sync_rise && (cnt_reg >= 5'(FRAME_BITS)))
            begin
                frame_reg <= shift_reg;
            end
        end
    end

    // Serial output changes on clock rise, first bit at select fall
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rb_out_reg <= 1'b0;
        end
        else if (sync_fall || (frame_act && sclk_rise))
        begin
            rb_out_reg <= shift_reg[23];
        end
    end

    // Field split of the latched frame
    assign cmd_rd   = frame_reg[POS_RW];
    assign cmd_sel  = frame_reg[POS_SEL_HI:POS_SEL_LO];
    assign cmd_ch   = frame_reg[POS_CH_HI:POS_CH_LO];
    assign cmd_data = frame_reg[15:0];
    assign exec_func   = exec_reg && (cmd_sel == SEL_FUNC) && !cmd_rd;
    assign exec_reg_ok = exec_reg && is_chan_sel(cmd_sel) && (cmd_ch <= CH_ALL);

    // Sequencer for channel writes and reads
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            chan_reg  <= 2'h0;
            all_reg   <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (exec_reg_ok)
                    begin
                        chan_reg <= cmd_ch[1:0];
                        all_reg  <= (cmd_ch == CH_ALL);
                        state_reg <= cmd_rd ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (all_reg && chan_reg != CH_D[1:0])
                    begin
                        chan_reg <= chan_reg + 2'h1;
                    end
                    else
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_READ:
                begin
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign mem_we = (state_reg == ST_WRITE);

    dscd_regmem u_mem (
        .clk    (clk),
        .resetn (resetn),
        .we     (mem_we),
        .waddr  ({mem_type(cmd_sel), chan_reg}),
        .wdata  (cmd_data & field_mask(cmd_sel)),
        .raddr  ({mem_type(cmd_sel), cmd_ch[1:0]}),
        .rdata  (rdata)
    );

    // Control view: input pins report their sampled level
    always_comb
    begin
        ctrl_view = 16'h0000;
        ctrl_view[5:0] = ctrl_reg;
        if (!ctrl_reg[CTL_DIR1])
        begin
            ctrl_view[CTL_VAL1] = io1_q[1];
        end
        if (!ctrl_reg[CTL_DIR0])
        begin
            ctrl_view[CTL_VAL0] = io0_q[1];
        end
    end

    // Readback word: echoed header and register contents
    assign rb_load = (state_reg == ST_READ)
                   || (exec_reg && cmd_rd && cmd_sel == SEL_FUNC);
    assign rb_word = {frame_reg[23:HDR_LO], (state_reg == ST_READ) ? rdata : ctrl_view};

    // Written control bits; value of an input pin keeps its old state
    always_comb
    begin
        ctrl_next = cmd_data[5:0];
        if (!cmd_data[CTL_DIR1])
        begin
            ctrl_next[CTL_VAL1] = ctrl_reg[CTL_VAL1];
        end
        if (!cmd_data[CTL_DIR0])
        begin
            ctrl_next[CTL_VAL0] = ctrl_reg[CTL_VAL0];
        end
    end

    // Function register execution
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg <= CTRL_RESET;
            wipe_reg <= 1'b0;
            load_reg <= 1'b0;
        end
        else
        begin
            wipe_reg <= exec_func && (cmd_ch == FN_CLEAR);
            load_reg <= exec_func && (cmd_ch == FN_LOAD);
            if (exec_func && (cmd_ch == FN_CTRL))
            begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    // Pin and status outputs
    assign io_pin_one_out       = ctrl_reg[CTL_VAL1];
    assign io_pin_one_oe_n      = ~ctrl_reg[CTL_DIR1];
    assign io_pin_zero_out      = ctrl_reg[CTL_VAL0];
    assign io_pin_zero_oe_n     = ~ctrl_reg[CTL_DIR0];
    assign local_gnd_adj_en     = ctrl_reg[CTL_LGO];
    assign serial_readback_oe_n = ctrl_reg[CTL_RB_DIS];
    assign serial_readback_out  = rb_out_reg;
    assign dac_clear_pulse      = wipe_reg;
    assign dac_load_pulse       = load_reg;

    // Checks
    property p_frame_len;
        @(posedge clk) disable iff (!resetn)
        (sync_rise && cnt_reg < 5'(FRAME_BITS)) |=> !exec_reg;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("short frame executed");

    property p_latch;
        @(posedge clk) disable iff (!resetn)
        (sync_rise && cnt_reg >= 5'(FRAME_BITS)) |=> (exec_reg && frame_reg == $past(shift_reg));
    endproperty
    a_latch: assert property (p_latch) else $error("frame not latched");

    property p_no_op;
        @(posedge clk) disable iff (!resetn)
        (exec_func && cmd_ch == FN_NO_OP) |=> ($stable(ctrl_reg) && !wipe_reg && !load_reg);
    endproperty
    a_no_op: assert property (p_no_op) else $error("no-op changed state");

    property p_ctrl_wr;
        @(posedge clk) disable iff (!resetn)
        (exec_func && cmd_ch == FN_CTRL) |=>
            (local_gnd_adj_en == $past(cmd_data[CTL_LGO])
             && serial_readback_oe_n == $past(cmd_data[CTL_RB_DIS]));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_in_value;
        @(posedge clk) disable iff (!resetn)
        (exec_func && cmd_ch == FN_CTRL && !cmd_data[CTL_DIR0]) |=> $stable(io_pin_zero_out);
    endproperty
    a_in_value: assert property (p_in_value) else $error("input value bit written");

    property p_dir;
        @(posedge clk) disable iff (!resetn)
        (exec_func && cmd_ch == FN_CTRL) |=> (io_pin_one_oe_n == !$past(cmd_data[CTL_DIR1]));
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");

    property p_clear;
        @(posedge clk) disable iff (!resetn)
        (exec_func && cmd_ch == FN_CLEAR) |=> (dac_clear_pulse ##1 !dac_clear_pulse);
    endproperty
    a_clear: assert property (p_clear) else $error("clear pulse wrong");

    property p_load;
        @(posedge clk) disable iff (!resetn)
        dac_load_pulse |-> ($past(exec_func) && $past(cmd_ch) == FN_LOAD);
    endproperty
    a_load: assert property (p_load) else $error("load without command");

    property p_all;
        @(posedge clk) disable iff (!resetn)
        (exec_reg_ok && !cmd_rd && cmd_ch == CH_ALL) |=> mem_we [*4] ##1 !mem_we;
    endproperty
    a_all: assert property (p_all) else $error("broadcast write not four");

    property p_undef;
        @(posedge clk) disable iff (!resetn)
        (exec_reg && !is_chan_sel(cmd_sel) && cmd_sel != SEL_FUNC) |=>
            ($stable(ctrl_reg) && state_reg == ST_IDLE && !rb_load);
    endproperty
    a_undef: assert property (p_undef) else $error("undefined frame acted");

    property p_read;
        @(posedge clk) disable iff (!resetn)
        (exec_reg_ok && cmd_rd) |=> rb_load ##1 (shift_reg[15:0] == $past(rdata));
    endproperty
    a_read: assert property (p_read) else $error("readback not loaded");
endmodule
`default_nettype wire

// ### logic/dscd_pkg.sv
`default_nettype none
package dscd_pkg;
    // Frame layout
    localparam int          FRAME_BITS = 24;
    localparam logic [4:0]  CNT_MAX    = 5'h1f;
    localparam int          POS_RW     = 23;
    localparam int          POS_SEL_HI = 21;
    localparam int          POS_SEL_LO = 19;
    localparam int          POS_CH_HI  = 18;
    localparam int          POS_CH_LO  = 16;
    localparam int          HDR_LO     = 16;

    // Target select codes
    localparam logic [2:0]  SEL_FUNC   = 3'h0;
    localparam logic [2:0]  SEL_DATA   = 3'h2;
    localparam logic [2:0]  SEL_COARSE = 3'h3;
    localparam logic [2:0]  SEL_FINE   = 3'h4;
    localparam logic [2:0]  SEL_OFFSET = 3'h5;

    // Channel codes
    localparam logic [2:0]  CH_D       = 3'h3;
    localparam logic [2:0]  CH_ALL     = 3'h4;

    // Function register addresses
    localparam logic [2:0]  FN_NO_OP   = 3'h0;
    localparam logic [2:0]  FN_CTRL    = 3'h1;
    localparam logic [2:0]  FN_CLEAR   = 3'h4;
    localparam logic [2:0]  FN_LOAD    = 3'h5;

    // Control bit positions
    localparam int          CTL_W      = 6;
    localparam int          CTL_LGO    = 5;
    localparam int          CTL_DIR1   = 4;
    localparam int          CTL_VAL1   = 3;
    localparam int          CTL_DIR0   = 2;
    localparam int          CTL_VAL0   = 1;
    localparam int          CTL_RB_DIS = 0;

    // Reset values
    localparam logic [5:0]  CTRL_RESET = 6'h00;
    localparam logic [15:0] MEM_RESET  = 16'h0000;

    // Implemented field widths per register type
    localparam logic [15:0] MASK_DATA   = 16'hffff;
    localparam logic [15:0] MASK_COARSE = 16'h0003;
    localparam logic [15:0] MASK_FINE   = 16'h003f;
    localparam logic [15:0] MASK_OFFSET = 16'h00ff;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } dscd_state_t;
endpackage
`default_nettype wire

// ### logic/dscd_regmem.sv
`default_nettype none
module dscd_regmem (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  raddr,
    output var  logic [15:0] rdata
);
    import dscd_pkg::*;

    logic [15:0] mem [16];

    // Channel register array, zero code after reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 16; i++)
            begin
                mem[i] <= MEM_RESET;
            end
        end
        else if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= MEM_RESET;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ### verif/dscd_host.sv
`default_nettype none
module dscd_host (
    output var  logic sclk,
    output var  logic sync_n,
    output var  logic sdin,
    input  wire logic rb_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link idles with clock high and frame select released
    initial
    begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        sdin   = 1'b0;
    end

    // One frame: bits launched before each fall, readback taken late in the low phase
    task automatic xfer(input logic [23:0] frame, input int nbits, output logic [23:0] got);
        int i;
        #100;
        got    = 24'h0;
        sync_n = 1'b0;
        for (i = 0; i < nbits; i++)
        begin
            sdin = frame[23 - i];
            #400;
            sclk = 1'b0;
            #400;
            got  = {got[22:0], rb_in};
            sclk = 1'b1;
        end
        #400;
        sync_n = 1'b1;
        sdin   = ~sdin; // Released line shows no stale level
        #1200;
    endtask
endmodule
`default_nettype wire

// ### verif/test_dac_serial_command_decoder.sv
`default_nettype none
module test_dac_serial_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import dscd_pkg::*;

    typedef struct {
        logic [23:0] wr;
        logic [2:0]  sel;
        logic [2:0]  ch;
        logic [15:0] exp;
    } dscd_row_t;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ext0 = 1'b0;
    logic        ext1 = 1'b1;
    wire logic   sclk, sync_n, sdin, sro, sro_oe_n;
    wire logic   p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
    wire logic   lgo, wipe_p, ld_p;
    int          mismatches = 0;
    int          n_checks = 0;
    int          n_wipe = 0;
    int          n_ld = 0;
    logic [23:0] g;
    dscd_row_t   rows [9] = '{
        '{24'h11a5c3, SEL_DATA, 3'h1, 16'ha5c3}, '{24'h1affff, SEL_COARSE, 3'h2, 16'h0003},
        '{24'h23ffff, SEL_FINE, 3'h3, 16'h003f}, '{24'h281234, SEL_OFFSET, 3'h0, 16'h0034},
        '{24'h145a5a, SEL_DATA, 3'h3, 16'h5a5a}, '{24'h08ffff, SEL_DATA, 3'h0, 16'h5a5a},
        '{24'h150000, SEL_DATA, 3'h1, 16'h5a5a}, '{24'h30ffff, SEL_DATA, 3'h2, 16'h5a5a},
        '{24'h38ffff, SEL_DATA, 3'h0, 16'h5a5a}};

    // Pin levels: device drives when enabled, else the outside world
    assign p0_in = p0_oe_n ? ext0 : p0_out;
    assign p1_in = p1_oe_n ? ext1 : p1_out;

    always #50 clk = ~clk;

    // Count strobe cycles
    always @(posedge clk)
    begin
        if (wipe_p === 1'b1) n_wipe++;
        if (ld_p === 1'b1) n_ld++;
    end

    dscd_top uut (
        .clk                  (clk),
        .resetn               (resetn),
        .sclk_in              (sclk),
        .sync_n_in            (sync_n),
        .sdin                 (sdin),
        .serial_readback_out  (sro),
        .serial_readback_oe_n (sro_oe_n),
        .io_pin_zero_in       (p0_in),
        .io_pin_zero_out      (p0_out),
        .io_pin_zero_oe_n     (p0_oe_n),
        .io_pin_one_in        (p1_in),
        .io_pin_one_out       (p1_out),
        .io_pin_one_oe_n      (p1_oe_n),
        .local_gnd_adj_en     (lgo),
        .dac_clear_pulse      (wipe_p),
        .dac_load_pulse       (ld_p)
    );

    dscd_host host (
        .sclk   (sclk),
        .sync_n (sync_n),
        .sdin   (sdin),
        .rb_in  (sro)
    );

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Control outputs packed: gnd adj, dir1_n, val1, dir0_n, val0, serial off
    task automatic ctl(input logic [5:0] e);
        chk({18'h0, lgo, p1_oe_n, p1_out, p0_oe_n, p0_out, sro_oe_n}, {18'h0, e});
    endtask

    // Read request, then a filler frame that carries the answer out
    task automatic rd(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] e);
        host.xfer({2'b10, sel, ch, 16'h0}, 24, g);
        host.xfer(24'h0, 24, g);
        chk(g, {2'b10, sel, ch, e});
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial
    begin
        #3000000;
        mismatches++;
        results();
    end

    initial
    begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        ctl(6'h14);
        // Write then read back each row
        foreach (rows[i])
        begin
            host.xfer(rows[i].wr, 24, g);
            rd(rows[i].sel, rows[i].ch, rows[i].exp);
        end
        // Control write with both pins as outputs
        host.xfer(24'h01fff6, 24, g);
        ctl(6'h22);
        host.xfer(24'h00ffff, 24, g);
        ctl(6'h22);
        host.xfer(24'h02ffff, 24, g);
        ctl(6'h22);
        // Pins back to inputs; written value bits must not land
        host.xfer(24'h01000a, 24, g);
        ctl(6'h16);
        @(negedge clk);
        ext1 = 1'b1;
        ext0 = 1'b0;
        rd(SEL_FUNC, FN_CTRL, 16'h0008);
        host.xfer(24'h010001, 24, g);
        ctl(6'h17);
        host.xfer(24'h010000, 24, g);
        ctl(6'h16);
        // Software clear and load strobes, one cycle each
        host.xfer(24'h04ffff, 24, g);
        chk(24'(n_wipe), 24'h1);
        chk(24'(n_ld), 24'h0);
        host.xfer(24'h05ffff, 24, g);
        chk(24'(n_ld), 24'h1);
        chk(24'(n_wipe), 24'h1);
        // Short frame is discarded
        host.xfer(24'h10ffff, 23, g);
        rd(SEL_DATA, 3'h0, 16'h5a5a);
        // Reset in mid-run brings back the defaults
        host.xfer(24'h01003f, 24, g);
        ctl(6'h2b);
        @(negedge clk);
        resetn = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        ctl(6'h14);
        rd(SEL_DATA, 3'h0, 16'h0000);
        results();
    end
endmodule
`default_nettype wire
